// >>> rwt_pkg.sv
/*
 * Shared constants for the reload timer and the wake-up timer block:
 * register offsets, control field positions, reset values and codes.
 * Assumes an 8-bit register port with byte addresses as offsets.
 */
`default_nettype none
package rwt_pkg;
    // Register offsets
    localparam logic [7:0] RWT_OFS_T3_CTRL     = 8'h1e;
    localparam logic [7:0] RWT_OFS_T3_RELOAD_H = 8'h1f;
    localparam logic [7:0] RWT_OFS_T3_RELOAD_L = 8'h20;
    localparam logic [7:0] RWT_OFS_T3_COUNT_H  = 8'h21;
    localparam logic [7:0] RWT_OFS_T3_COUNT_L  = 8'h22;
    localparam logic [7:0] RWT_OFS_WK_CTRL     = 8'h23;
    localparam logic [7:0] RWT_OFS_WK_RELOAD_H = 8'h24;
    localparam logic [7:0] RWT_OFS_WK_RELOAD_L = 8'h25;
    // Timer3 control fields
    localparam int T3_STOP_RX_BIT   = 7;
    localparam int T3_START_LSB     = 4;
    localparam int T3_AUTO_RELOAD   = 3;
    localparam int T3_CLK_LSB       = 0;
    // Wake-up timer control fields
    localparam int WK_RUNNING_BIT   = 7;
    localparam int WK_RUN_WE_BIT    = 6;
    localparam int WK_AUTO_TRIM_BIT = 5;
    localparam int WK_AUTO_CD_BIT   = 4;
    localparam int WK_AUTO_RELOAD   = 3;
    localparam int WK_AUTO_WAKE_BIT = 2;
    localparam int WK_CLK_LSB       = 0;
    // Reset values
    localparam logic [7:0]  RWT_BYTE_RST  = 8'h00;
    localparam logic [15:0] RWT_COUNT_RST = 16'h0000;
    // Timer3 start selection codes
    localparam logic [1:0] T3_START_NONE    = 2'h0;
    localparam logic [1:0] T3_START_TX_END  = 2'h1;
    localparam logic [1:0] T3_START_TRIM    = 2'h2;
    localparam logic [1:0] T3_START_TRIM_UF = 2'h3;
    // Timer3 clock selection codes
    localparam logic [1:0] T3_CLK_CORE = 2'h0;
    localparam logic [1:0] T3_CLK_211K = 2'h1;
    localparam logic [1:0] T3_CLK_T0UF = 2'h2;
    localparam logic [1:0] T3_CLK_T1UF = 2'h3;
    // Low-frequency oscillator divider terminal counts (divide by 8, 16, 32)
    localparam logic [4:0] LFO_DIV8_LAST  = 5'h07;
    localparam logic [4:0] LFO_DIV16_LAST = 5'h0f;
    localparam logic [4:0] LFO_DIV32_LAST = 5'h1f;
    // Card detection sequence states, Gray coded along the path
    typedef enum logic [1:0] {
        RWT_CD_IDLE   = 2'b00,
        RWT_CD_FIELD  = 2'b01,
        RWT_CD_DECIDE = 2'b11
    } rwt_cd_t;
endpackage : rwt_pkg
`default_nettype wire

// >>> rwt_lfo_div.sv
/*
 * Divider for the low-frequency oscillator tick: passes it undivided or
 * divided by 8, 16 or 32 as the clock select asks.
 * Assumes lfo_tick is a one-cycle pulse synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rwt_lfo_div (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    // Oscillator tick and selection
    input  wire logic       lfo_tick,
    input  wire logic [1:0] sel,
    // Divided tick
    output logic            tick_r
);
    import rwt_pkg::*;

    logic [4:0] div_cnt_r;  // Oscillator ticks seen since the last output
    logic [4:0] last;       // Terminal count for the chosen ratio

    // Terminal count decode
    always_comb begin
        unique case (sel)
            2'b00: last = 5'h00;
            2'b01: last = LFO_DIV8_LAST;
            2'b10: last = LFO_DIV16_LAST;
            2'b11: last = LFO_DIV32_LAST;
        endcase
    end

    // Divider counter and tick; the output is registered, so ticks lag by one cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            div_cnt_r <= 5'h00;
            tick_r    <= 1'b0;
        end else if (ce) begin
            tick_r <= 1'b0;
            if (lfo_tick) begin
                if (div_cnt_r >= last) begin
                    div_cnt_r <= 5'h00;
                    tick_r    <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 5'h01;
                end
            end
        end
    end
endmodule : rwt_lfo_div
`default_nettype wire

// >>> rwt_timers.sv
/*
 * Reload timer (timer3) and wake-up timer with card detection sequencing.
 * Assumes a synchronous 8-bit register port, one-cycle event pulses on all
 * tick and event inputs, and a single 250 MHz clock with clock enable.
 */
// Behaviour
// - Start event loads both timer3 reload bytes
// - Timer3 count readable as high and low bytes
// - Control bit 7 shows wake timer running
// - Run bit writes take effect only with bit 6 set
// - Auto trim launches trimming on wake underflow
// - Auto card detect runs sequence on underflow
// - Card found raises request, may stay active
// - No card enters power-down with auto wake set; wake timer continues
// - Timer3 times the field-on interval
// - Wake auto-reload or auto card detect restarts, else stops at zero
// - Wake underflow sets interrupt flag
// - Auto wake leaves power-down on underflow
// - Clock select picks divide 1, 8, 16, 32
// - Wake timer loads reload value at start
// - Timer3 auto-reload restarts, else stops at zero
// - Timer3 clock select picks four sources
// - Timer3 start selection modes
// - Wake reload low byte writable separately
`timescale 1ns/1ps
`default_nettype none
module rwt_timers (
    // Clock, reset, enable
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata_r,
    // Timer3 clock and event sources
    input  wire logic       tick_211k,
    input  wire logic       timer0_underflow,
    input  wire logic       timer1_underflow,
    input  wire logic       tx_end,
    input  wire logic       rx_first_nibble,
    input  wire logic       timer3_start_cmd,
    input  wire logic       timer3_stop_cmd,
    // Wake-up side inputs
    input  wire logic       lfo_tick,
    input  wire logic       card_present,
    input  wire logic       card_stay_active,
    input  wire logic       irq_flag_clear,
    // Event and state outputs
    output logic            timer3_underflow_r,
    output logic            wake_timer_irq_flag,
    output logic            card_irq_r,
    output logic            osc_trim_start_r,
    output logic            rf_field_on_r,
    output logic            power_down_r
);
    import rwt_pkg::*;

    // Registers; only control, reload and timer3 count bytes are readable
    logic [7:0]  t3_ctrl_r;        // Stop on rx, start select, auto reload, clock
    logic [7:0]  t3_reload_h_r;    // Timer3 reload high byte
    logic [7:0]  t3_reload_l_r;    // Timer3 reload low byte
    logic [15:0] t3_cnt_r;         // Timer3 live count
    logic        t3_run_r;         // Timer3 counting
    logic [5:0]  wk_cfg_r;         // Wake control bits 5..0
    logic        wk_run_r;         // Wake timer counting
    logic [7:0]  wk_reload_h_r;    // Wake reload high byte
    logic [7:0]  wk_reload_l_r;    // Wake reload low byte
    logic [15:0] wk_cnt_r;         // Wake timer live count
    logic        irq_flag_r;       // Sticky wake underflow flag
    rwt_cd_t     cd_state_r;       // Card detection sequence state

    // Decoded strobes and events
    logic        wr_ctrl;          // Write to wake control
    logic        wk_cmd;           // Write that may start or stop the wake timer
    logic        wk_tick;          // Divided oscillator tick
    logic        wk_uf;            // Wake timer steps from zero
    logic        t3_tick;          // Selected timer3 input tick
    logic        t3_uf;            // Timer3 steps from zero
    logic        t3_start;         // Any timer3 start event
    logic        t3_stop;          // Any timer3 stop event
    logic        trim_mode;        // Timer3 used for oscillator trimming
    logic        cd_launch;        // Card detection begins this cycle

    // Write strobe for one register offset
    function automatic logic reg_hit(input logic [7:0] ofs);
        reg_hit = ce && reg_wr && (reg_addr == ofs);
    endfunction : reg_hit

    // Concatenated reload value
    function automatic logic [15:0] word16(input logic [7:0] hi, input logic [7:0] lo);
        word16 = {hi, lo};
    endfunction : word16

    // Oscillator divider for the wake timer clock
    rwt_lfo_div u_lfo_div (
        .clock    (clock),
        .rst      (rst),
        .ce       (ce),
        .lfo_tick (lfo_tick),
        .sel      (wk_cfg_r[WK_CLK_LSB +: 2]),
        .tick_r   (wk_tick)
    );

    assign wr_ctrl   = reg_hit(RWT_OFS_WK_CTRL);
    assign wk_cmd    = wr_ctrl && reg_wdata[WK_RUN_WE_BIT];
    // A host start/stop in the same cycle takes priority over an underflow
    assign wk_uf     = ce && wk_run_r && wk_tick && (wk_cnt_r == RWT_COUNT_RST) && !wk_cmd;
    assign trim_mode = t3_ctrl_r[T3_START_LSB+1];
    assign cd_launch = wk_uf && wk_cfg_r[WK_AUTO_CD_BIT] && (cd_state_r == RWT_CD_IDLE);

    // Timer3 input clock selection
    always_comb begin
        unique case (t3_ctrl_r[T3_CLK_LSB +: 2])
            T3_CLK_CORE: t3_tick = 1'b1;   // Core clock stands in for the carrier
            T3_CLK_211K: t3_tick = tick_211k;
            T3_CLK_T0UF: t3_tick = timer0_underflow;
            T3_CLK_T1UF: t3_tick = timer1_underflow;
        endcase
    end

    // Timer3 start and stop events
    always_comb begin
        unique case (t3_ctrl_r[T3_START_LSB +: 2])
            T3_START_NONE:    t3_start = timer3_start_cmd;
            T3_START_TX_END:  t3_start = timer3_start_cmd || tx_end;
            T3_START_TRIM,
            T3_START_TRIM_UF: t3_start = timer3_start_cmd || osc_trim_start_r;
        endcase
        t3_start = ce && (t3_start || cd_launch);
        // Stop on first received nibble has no effect while trimming
        t3_stop  = ce && (timer3_stop_cmd ||
                   (t3_ctrl_r[T3_STOP_RX_BIT] && rx_first_nibble && !trim_mode));
    end

    assign t3_uf = ce && t3_run_r && t3_tick && (t3_cnt_r == RWT_COUNT_RST) && !t3_start;

    // Timer3 configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            t3_ctrl_r     <= RWT_BYTE_RST;
            t3_reload_h_r <= RWT_BYTE_RST;
            t3_reload_l_r <= RWT_BYTE_RST;
        end else begin
            // Bits 6 and 2 are reserved and stay zero
            if (reg_hit(RWT_OFS_T3_CTRL))
                t3_ctrl_r <= reg_wdata & 8'hbb;
            if (reg_hit(RWT_OFS_T3_RELOAD_H))
                t3_reload_h_r <= reg_wdata;
            // Held here only; the count sees it at the next start event or auto reload
            if (reg_hit(RWT_OFS_T3_RELOAD_L))
                t3_reload_l_r <= reg_wdata;
        end
    end

    // Timer3 counter
    always_ff @(posedge clock) begin
        if (rst) begin
            t3_cnt_r <= RWT_COUNT_RST;
            t3_run_r <= 1'b0;
        end else if (ce) begin
            if (t3_start) begin
                t3_cnt_r <= word16(t3_reload_h_r, t3_reload_l_r);
                t3_run_r <= 1'b1;
            end else if (t3_stop) begin
                t3_run_r <= 1'b0;
            end else if (t3_uf) begin
                // Without auto reload the count rests at zero once stopped
                if (t3_ctrl_r[T3_AUTO_RELOAD])
                    t3_cnt_r <= word16(t3_reload_h_r, t3_reload_l_r);
                t3_run_r <= t3_ctrl_r[T3_AUTO_RELOAD];
            end else if (t3_run_r && t3_tick) begin
                t3_cnt_r <= t3_cnt_r - 16'h0001;
            end
        end
    end

    // Timer3 underflow pulse
    always_ff @(posedge clock) begin
        if (rst)
            timer3_underflow_r <= 1'b0;
        else if (ce)
            timer3_underflow_r <= t3_uf;
    end

    // Wake timer configuration and reload registers
    always_ff @(posedge clock) begin
        if (rst) begin
            wk_cfg_r      <= 6'h00;
            wk_reload_h_r <= RWT_BYTE_RST;
            wk_reload_l_r <= RWT_BYTE_RST;
        end else begin
            if (wr_ctrl)
                wk_cfg_r <= reg_wdata[5:0];
            if (reg_hit(RWT_OFS_WK_RELOAD_H))
                wk_reload_h_r <= reg_wdata;
            if (reg_hit(RWT_OFS_WK_RELOAD_L))
                wk_reload_l_r <= reg_wdata;
        end
    end

    // Wake timer counter and running state
    always_ff @(posedge clock) begin
        if (rst) begin
            wk_cnt_r <= RWT_COUNT_RST;
            wk_run_r <= 1'b0;
        end else if (ce) begin
            if (wk_cmd) begin
                wk_run_r <= reg_wdata[WK_RUNNING_BIT];
                if (reg_wdata[WK_RUNNING_BIT])
                    wk_cnt_r <= word16(wk_reload_h_r, wk_reload_l_r);
            end else if (wk_uf) begin
                // Card detection keeps the timer going with no gap
                if (wk_cfg_r[WK_AUTO_RELOAD] || wk_cfg_r[WK_AUTO_CD_BIT]) begin
                    wk_cnt_r <= word16(wk_reload_h_r, wk_reload_l_r);
                end else begin
                    wk_run_r <= 1'b0;
                end
            end else if (wk_run_r && wk_tick) begin
                wk_cnt_r <= wk_cnt_r - 16'h0001;
            end
        end
    end

    // Sticky underflow flag; a new underflow beats a simultaneous clear
    always_ff @(posedge clock) begin
        if (rst)
            irq_flag_r <= 1'b0;
        else if (ce) begin
            if (wk_uf)
                irq_flag_r <= 1'b1;
            else if (irq_flag_clear)
                irq_flag_r <= 1'b0;
        end
    end
    assign wake_timer_irq_flag = irq_flag_r;

    // Oscillator trim launch pulse
    always_ff @(posedge clock) begin
        if (rst)
            osc_trim_start_r <= 1'b0;
        else if (ce)
            osc_trim_start_r <= wk_uf && wk_cfg_r[WK_AUTO_TRIM_BIT];
    end

    // Card detection sequence: field on, timer3 times it, then decide
    always_ff @(posedge clock) begin
        if (rst) begin
            cd_state_r    <= RWT_CD_IDLE;
            rf_field_on_r <= 1'b0;
            card_irq_r    <= 1'b0;
        end else if (ce) begin
            card_irq_r <= 1'b0;
            unique case (cd_state_r)
                RWT_CD_IDLE: begin
                    if (cd_launch) begin
                        cd_state_r    <= RWT_CD_FIELD;
                        rf_field_on_r <= 1'b1;
                    end
                end
                RWT_CD_FIELD: begin
                    // Field interval ends on timer3 underflow or once timer3 is not running
                    if (t3_uf || !t3_run_r)
                        cd_state_r <= RWT_CD_DECIDE;
                end
                RWT_CD_DECIDE: begin
                    cd_state_r    <= RWT_CD_IDLE;
                    rf_field_on_r <= 1'b0;
                    card_irq_r    <= card_present;
                end
                default: begin
                    cd_state_r    <= RWT_CD_IDLE;
                    rf_field_on_r <= 1'b0;
                end
            endcase
        end
    end

    // Power-down state: with auto wake set, entered after an empty detection and left on underflow
    always_ff @(posedge clock) begin
        if (rst)
            power_down_r <= 1'b0;
        else if (ce) begin
            if (cd_state_r == RWT_CD_DECIDE && card_present && card_stay_active)
                power_down_r <= 1'b0;
            else if (cd_state_r == RWT_CD_DECIDE && !card_present &&
                     wk_cfg_r[WK_AUTO_WAKE_BIT])
                power_down_r <= 1'b1;
            else if (wk_uf && wk_cfg_r[WK_AUTO_WAKE_BIT])
                power_down_r <= 1'b0;
        end
    end

    // Read data; count bytes are live, so reads during reception may tear
    always_ff @(posedge clock) begin
        if (rst)
            reg_rdata_r <= RWT_BYTE_RST;
        else if (ce && reg_rd) begin
            unique case (reg_addr)
                RWT_OFS_T3_CTRL:     reg_rdata_r <= t3_ctrl_r;
                RWT_OFS_T3_RELOAD_H: reg_rdata_r <= t3_reload_h_r;
                RWT_OFS_T3_RELOAD_L: reg_rdata_r <= t3_reload_l_r;
                RWT_OFS_T3_COUNT_H:  reg_rdata_r <= t3_cnt_r[15:8];
                RWT_OFS_T3_COUNT_L:  reg_rdata_r <= t3_cnt_r[7:0];
                RWT_OFS_WK_CTRL:     reg_rdata_r <= {wk_run_r, 1'b0, wk_cfg_r};
                RWT_OFS_WK_RELOAD_H: reg_rdata_r <= wk_reload_h_r;
                RWT_OFS_WK_RELOAD_L: reg_rdata_r <= wk_reload_l_r;
                default:             reg_rdata_r <= RWT_BYTE_RST;  // Unmapped reads zero
            endcase
        end
    end

    // Checks
    sequence s_wk_start;
        ce && wk_cmd && reg_wdata[WK_RUNNING_BIT];
    endsequence
    sequence s_cd_empty;
        ce && cd_state_r == RWT_CD_DECIDE && !card_present && wk_cfg_r[WK_AUTO_WAKE_BIT];
    endsequence

    a_wake_start_load: assert property (@(posedge clock) disable iff (rst)
        s_wk_start |=> wk_run_r && wk_cnt_r == $past(word16(wk_reload_h_r, wk_reload_l_r)))
        else $error("wake timer did not load reload value on start");
    a_run_needs_we: assert property (@(posedge clock) disable iff (rst)
        (ce && wr_ctrl && !reg_wdata[WK_RUN_WE_BIT] && !wk_uf) |=> wk_run_r == $past(wk_run_r))
        else $error("running bit changed without write enable");
    a_underflow_flag: assert property (@(posedge clock) disable iff (rst)
        wk_uf |=> irq_flag_r)
        else $error("underflow did not set flag");
    a_stop_at_zero: assert property (@(posedge clock) disable iff (rst)
        (wk_uf && !wk_cfg_r[WK_AUTO_RELOAD] && !wk_cfg_r[WK_AUTO_CD_BIT]) |=> !wk_run_r)
        else $error("wake timer kept running at zero");
    a_wake_reload: assert property (@(posedge clock) disable iff (rst)
        (wk_uf && wk_cfg_r[WK_AUTO_RELOAD]) |=> wk_run_r &&
        wk_cnt_r == $past(word16(wk_reload_h_r, wk_reload_l_r)))
        else $error("wake timer did not reload");
    a_trim_launch: assert property (@(posedge clock) disable iff (rst)
        (wk_uf && wk_cfg_r[WK_AUTO_TRIM_BIT]) |=> osc_trim_start_r ##1 !osc_trim_start_r || !ce)
        else $error("trim launch missing or not one cycle");
    a_cd_field: assert property (@(posedge clock) disable iff (rst)
        cd_launch |=> rf_field_on_r && t3_run_r &&
        t3_cnt_r == $past(word16(t3_reload_h_r, t3_reload_l_r)))
        else $error("card detect did not start field and timer3");
    a_cd_powerdown: assert property (@(posedge clock) disable iff (rst)
        s_cd_empty |=> power_down_r && !rf_field_on_r)
        else $error("empty detection did not power down");
    a_t3_count_read: assert property (@(posedge clock) disable iff (rst)
        (ce && reg_rd && reg_addr == RWT_OFS_T3_COUNT_H) |=> reg_rdata_r == $past(t3_cnt_r[15:8]))
        else $error("count high byte read wrong");
endmodule : rwt_timers
`default_nettype wire

// >>> tb_rwt_timers.sv
/*
 * Self-checking bench for the reload timer and wake-up timer block.
 * Assumes one-cycle register strobes with registered read data and a 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_rwt_timers;
    import rwt_pkg::*;
    // Stimulus and observed signals
    logic       clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r, rv;
    logic       tick_211k = 0, tx_end = 0, timer3_start_cmd = 0, lfo_tick = 0;
    logic       card_present = 0, card_stay_active = 0, irq_flag_clear = 0;
    logic       ce = 1, timer0_underflow = 0, timer1_underflow = 0;
    logic       timer3_underflow_r, wake_timer_irq_flag, card_irq_r;
    logic       osc_trim_start_r, rf_field_on_r, power_down_r;
    logic [31:0] seed = 32'h71c467b3;  // Fixed seed keeps runs repeatable
    logic [15:0] rl;                   // Expected timer3 count
    int n_mismatch = 0, n_checks = 0, n, m, n_card = 0, n_trim = 0, n_rf = 0, n_t3 = 0;
    // Free-running 4 ns clock
    always #2 clock = ~clock;
    // Event tallies; one-cycle pulses count once each, the field level counts its cycles
    always @(posedge clock) begin
        if (card_irq_r === 1'b1) n_card++;
        if (osc_trim_start_r === 1'b1) n_trim++;
        if (rf_field_on_r === 1'b1) n_rf++;
        if (timer3_underflow_r === 1'b1) n_t3++;
    end
    // Reception never runs here, so count reads are always legal
    rwt_timers i_rwt_timers (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .tick_211k(tick_211k), .timer0_underflow(timer0_underflow),
        .timer1_underflow(timer1_underflow),
        .tx_end(tx_end), .rx_first_nibble(1'b0), .timer3_start_cmd(timer3_start_cmd),
        .timer3_stop_cmd(1'b0), .lfo_tick(lfo_tick), .card_present(card_present),
        .card_stay_active(card_stay_active), .irq_flag_clear(irq_flag_clear),
        .timer3_underflow_r(timer3_underflow_r), .wake_timer_irq_flag(wake_timer_irq_flag),
        .card_irq_r(card_irq_r), .osc_trim_start_r(osc_trim_start_r),
        .rf_field_on_r(rf_field_on_r), .power_down_r(power_down_r));
    // Galois-free shift register step for random values
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd
    // Lowest divided-tick span in lfo ticks for a clock select code
    function automatic int div_of(input int sel);
        return (sel == 0) ? 1 : (4 << sel);
    endfunction : div_of
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data is registered at the taking edge and then holds
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        #1 rv = reg_rdata_r;
    endtask : rd
    // One-cycle pulse on a chosen event input, then three cycles to settle
    task automatic pulse(input int k);
        @(posedge clock);
        case (k)
            0: lfo_tick <= 1'b1;
            1: tick_211k <= 1'b1;
            2: timer3_start_cmd <= 1'b1;
            3: tx_end <= 1'b1;
            4: irq_flag_clear <= 1'b1;
            5: timer0_underflow <= 1'b1;
            default: timer1_underflow <= 1'b1;
        endcase
        @(posedge clock);
        {lfo_tick, tick_211k, timer3_start_cmd, tx_end, irq_flag_clear} <= 5'h00;
        {timer0_underflow, timer1_underflow} <= 2'h0;
        repeat (3) @(posedge clock);
        #1;
    endtask : pulse
    task automatic end_of_test;
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Watchdog: whole sequence needs about a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(8'h21); chk("count high at reset", 16'h0000, rv);
        rd(8'h40); chk("unmapped read", 16'h0000, rv);
        // Timer3: load at start, tick on the 211 kHz source only
        seed = rnd(seed);
        rl = {seed[15:8] | 8'h01, seed[7:0]};
        wr(RWT_OFS_T3_RELOAD_H, rl[15:8]);
        wr(RWT_OFS_T3_RELOAD_L, rl[7:0]);
        wr(RWT_OFS_T3_CTRL, 8'h01);
        rd(8'h20); chk("reload low", rl[7:0], rv);
        rd(8'h22); chk("count before start", 16'h0000, rv);
        pulse(2);
        rd(8'h21); chk("count high", rl[15:8], rv);
        rd(8'h22); chk("count low", rl[7:0], rv);
        n = seed[19:16];
        repeat (n) pulse(1);
        rl = rl - 16'(n);
        rd(8'h22); chk("count after ticks", rl[7:0], rv);
        // A tick while the enable is low must leave the count alone
        @(posedge clock);
        ce <= 1'b0;
        pulse(1);
        @(posedge clock);
        ce <= 1'b1;
        rd(8'h22); chk("count frozen without enable", rl[7:0], rv);
        wr(8'h20, ~seed[7:0]);
        rd(8'h22); chk("count kept until start", rl[7:0], rv);
        wr(RWT_OFS_T3_CTRL, 8'h11);
        pulse(3);
        rd(8'h22); chk("count at tx end start", 8'(~seed[7:0]), rv);
        // Underflow sources: only the selected one may step the count
        wr(RWT_OFS_T3_CTRL, 8'h12);
        pulse(5); pulse(6); pulse(1);
        rd(8'h22); chk("count on timer0 source", 8'(~seed[7:0] - 8'h01), rv);
        wr(RWT_OFS_T3_CTRL, 8'h13);
        pulse(5); pulse(6); pulse(1);
        rd(8'h22); chk("count on timer1 source", 8'(~seed[7:0] - 8'h02), rv);
        // Wake timer: control bit 6 gates the run bit, auto reload keeps it going
        m = seed[22:20] % 7 + 1;
        wr(8'h24, 8'h00);
        wr(8'h25, 8'(m));
        wr(8'h23, 8'hc0);
        wr(8'h23, 8'h08);
        rd(8'h23); chk("control with run kept", 16'h0088, rv);
        repeat (m) pulse(0);
        chk("flag before underflow", 16'h0000, 16'(wake_timer_irq_flag));
        pulse(0);
        chk("flag at underflow", 16'h0001, 16'(wake_timer_irq_flag));
        rd(8'h23); chk("running after reload", 16'h0088, rv);
        wr(8'h23, 8'h40);
        rd(8'h23); chk("stopped by write", 16'h0000, rv);
        // Clock select: count lfo ticks up to the second divided tick from 1
        wr(8'h25, 8'h01);
        for (int s = 0; s < 4; s++) begin
            pulse(4);
            wr(8'h23, 8'hc0 | 8'(s));
            n = 0;
            while (wake_timer_irq_flag !== 1'b1 && n < 80) begin
                pulse(0);
                n++;
            end
            chk("ticks to underflow", 16'h0001, 16'((s == 0) ? (n == 2) :
                (n > div_of(s) && n <= 2 * div_of(s))));
            rd(8'h23); chk("stopped at zero", 16'(s), rv);
        end
        // Auto trim on underflow, no power-down from trim alone
        wr(RWT_OFS_T3_CTRL, 8'h21);
        wr(8'h20, seed[7:0]);
        wr(8'h25, 8'h00);
        wr(8'h23, 8'he0);
        m = n_trim;
        pulse(0);
        chk("trim launches", 16'h0001, 16'(n_trim - m));
        chk("no power-down after trim", 16'h0000, 16'(power_down_r));
        rd(8'h22); chk("count at trim start", seed[7:0], rv);
        // Card detection, first empty then with a card present
        wr(RWT_OFS_T3_RELOAD_H, 8'h00);
        wr(RWT_OFS_T3_RELOAD_L, 8'h05);
        wr(RWT_OFS_T3_CTRL, 8'h00);
        wr(8'h23, 8'hd4);
        m = n_card;
        n_rf = 0;
        n_t3 = 0;
        pulse(0);
        repeat (20) @(posedge clock);
        #1;
        chk("field time", 16'h0001, 16'(n_rf >= 6 && n_rf <= 12));
        chk("power-down when empty", 16'h0001, 16'(power_down_r));
        rd(8'h23); chk("restarted", 16'h0094, rv & 8'hbf);
        chk("timer3 single underflow", 16'h0001, 16'(n_t3));
        rd(8'h22); chk("timer3 rests at zero", 16'h0000, rv);
        @(posedge clock);
        card_present <= 1'b1;
        card_stay_active <= 1'b1;
        pulse(0);
        repeat (20) @(posedge clock);
        #1;
        chk("card request", 16'h0001, 16'(n_card - m));
        chk("awake after underflow", 16'h0000, 16'(power_down_r));
        wr(8'h23, 8'h40);
        end_of_test;
    end
endmodule : tb_rwt_timers
`default_nettype wire
